// file: mdpc_top.sv
/*
  Monitor selection and line driver control with an AXI4-Lite register port.
  Assumes line receive pins are asynchronous and transmit data comes from
  logic on ref_clk_in. Line signals are modelled as digital mark pulses.
*/
`timescale 1ns/10ps
module mdpc_top
  import mdpc_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                arst_n_in,
  // AXI4-Lite write address
  input  wire logic                s_axi_awvalid_in,
  input  wire logic [3:0]          s_axi_awaddr_in,
  output logic                     s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic                s_axi_wvalid_in,
  input  wire logic [31:0]         s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  output logic                     s_axi_wready_out,
  // AXI4-Lite write response
  output logic                     s_axi_bvalid_out,
  output logic [1:0]               s_axi_bresp_out,
  input  wire logic                s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic                s_axi_arvalid_in,
  input  wire logic [3:0]          s_axi_araddr_in,
  output logic                     s_axi_arready_out,
  // AXI4-Lite read data
  output logic                     s_axi_rvalid_out,
  output logic [31:0]              s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  input  wire logic                s_axi_rready_in,
  // Line receive pins, channels 0..4
  input  wire logic [NUM_CH-1:0]   rx_line_tip_in,
  input  wire logic [NUM_CH-1:0]   rx_line_ring_in,
  // Transmit data from the framer side, channels 0..4
  input  wire logic [NUM_CH-1:0]   tx_data_tip_in,
  input  wire logic [NUM_CH-1:0]   tx_data_ring_in,
  // Line driver pins, channels 0..4
  output logic [NUM_CH-1:0]        tx_line_tip_out,
  output logic [NUM_CH-1:0]        tx_line_ring_out,
  output logic [NUM_CH-1:0]        tx_line_oe_out,
  // Channel 0 recovered signals
  output logic                     recovered_clock_out,
  output logic                     rx_data_positive_out,
  output logic                     rx_data_negative_out
);

  typedef struct packed {
    // Register bus
    logic              aw_got;
    logic [3:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_rdy;
    logic              w_rdy;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    // Control register
    logic [8:0]        ctrl;
    // Receive pin synchronisers
    logic [NUM_CH-1:0] tip_s1;
    logic [NUM_CH-1:0] tip_s2;
    logic [NUM_CH-1:0] ring_s1;
    logic [NUM_CH-1:0] ring_s2;
    // Line drivers
    logic [NUM_CH-1:0] drv_tip;
    logic [NUM_CH-1:0] drv_ring;
    logic [NUM_CH-1:0] drv_oe;
  } mdpc_state_t;

  mdpc_state_t q;
  mdpc_state_t d;

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Selector decode; codes 5..7 in the low bits are treated as off
  function automatic mdpc_sel_t decode_sel(input logic [3:0] code);
    mdpc_sel_t s;
    s.is_tx  = code[3];
    s.chan   = code[2:0];
    s.active = (code[2:0] != 3'h0) && (code[2:0] <= 3'h4);
    return s;
  endfunction

  // Byte-lane merge of a write into a 32-bit word
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Decoded controls
  // ==========================================================
  mdpc_sel_t   sel;
  logic        drv_en;
  logic        edge_sel;
  logic        rem_loop;
  logic        clk_mode;
  logic        mon_tip;
  logic        mon_ring;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  // Control fields seen by the datapath
  always_comb begin
    sel      = decode_sel(q.ctrl[CTRL_SEL_LSB +: 4]);
    drv_en   = q.ctrl[CTRL_OE_BIT];
    edge_sel = q.ctrl[CTRL_EDGE_BIT];
    rem_loop = q.ctrl[CTRL_RLB_BIT];
    clk_mode = q.ctrl[CTRL_CRM_BIT];
  end

  // Channel 0 receive input: own pins, or the observed pair
  always_comb begin
    mon_tip  = q.tip_s2[0];
    mon_ring = q.ring_s2[0];
    if (sel.active) begin
      if (sel.is_tx) begin
        // Observe what the selected driver sends; non-intrusive tap
        mon_tip  = tx_data_tip_in[sel.chan];
        mon_ring = tx_data_ring_in[sel.chan];
      end else begin
        mon_tip  = q.tip_s2[sel.chan];
        mon_ring = q.ring_s2[sel.chan];
      end
    end
  end

  // Readback words
  always_comb begin
    ctrl_word   = {23'h00_0000, q.ctrl};
    status_word = 32'h0000_0000;
    status_word[0]   = sel.active;
    status_word[1]   = sel.is_tx;
    status_word[4:2] = sel.chan;
    status_word[5]   = drv_en;
    // Flags a strap conflict; pin control mode expects this bit low
    status_word[6]   = q.ctrl[CTRL_ADDR_FOUR_BIT];
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    d = q;

    // Two-flop synchronisers on the asynchronous line pins
    d.tip_s1  = rx_line_tip_in;
    d.tip_s2  = q.tip_s1;
    d.ring_s1 = rx_line_ring_in;
    d.ring_s2 = q.ring_s1;

    // Write address and data are taken independently
    if (q.aw_rdy && s_axi_awvalid_in) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr_in;
    end
    if (q.w_rdy && s_axi_wvalid_in) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata_in;
      d.w_strb = s_axi_wstrb_in;
    end

    // Write response retires once accepted
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end

    // Both halves present: perform the write
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      if (q.aw_addr[3:2] == CTRL_OFS[3:2]) begin
        d.ctrl  = 9'(merge_strb(ctrl_word, q.w_data, q.w_strb));
        d.bresp = RESP_OKAY;
      end else if (q.aw_addr[3:2] == STATUS_OFS[3:2]) begin
        d.bresp = RESP_OKAY;                                      // Read-only, write ignored
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end

    // Read channel
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    if (q.ar_rdy && s_axi_arvalid_in) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      if (s_axi_araddr_in[3:2] == CTRL_OFS[3:2]) begin
        d.rdata = ctrl_word;
      end else if (s_axi_araddr_in[3:2] == STATUS_OFS[3:2]) begin
        d.rdata = status_word;
      end else begin
        d.rdata = 32'h0000_0000;
        d.rresp = RESP_SLVERR;
      end
    end

    // Ready flags registered so the ports come from flops
    d.aw_rdy = !d.aw_got && !d.bvalid;
    d.w_rdy  = !d.w_got && !d.bvalid;
    d.ar_rdy = !d.rvalid;

    // Line drivers; other channels keep sending while being observed
    d.drv_tip  = tx_data_tip_in;
    d.drv_ring = tx_data_ring_in;
    if (rem_loop) begin
      d.drv_tip[0]  = mon_tip;
      d.drv_ring[0] = mon_ring;
    end
    // Drive data held low while off so no stale mark leaks at enable
    if (!drv_en) begin
      d.drv_tip  = '0;
      d.drv_ring = '0;
    end
    d.drv_oe = {NUM_CH{drv_en}};
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q      <= '0;
      q.ctrl <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Channel 0 recovery, runs regardless of driver enable
  // ==========================================================
  mdpc_recover u_recover (
    .ref_clk_in           (ref_clk_in),
    .arst_n_in            (arst_n_in),
    .tip_in               (mon_tip),
    .ring_in              (mon_ring),
    .clock_mode_in        (clk_mode),
    .edge_sel_in          (edge_sel),
    .recovered_clock_out  (recovered_clock_out),
    .rx_data_positive_out (rx_data_positive_out),
    .rx_data_negative_out (rx_data_negative_out)
  );

  // ==========================================================
  // Port drive
  // ==========================================================
  assign s_axi_awready_out = q.aw_rdy;
  assign s_axi_wready_out  = q.w_rdy;
  assign s_axi_bvalid_out  = q.bvalid;
  assign s_axi_bresp_out   = q.bresp;
  assign s_axi_arready_out = q.ar_rdy;
  assign s_axi_rvalid_out  = q.rvalid;
  assign s_axi_rdata_out   = q.rdata;
  assign s_axi_rresp_out   = q.rresp;
  assign tx_line_tip_out   = q.drv_tip;
  assign tx_line_ring_out  = q.drv_ring;
  assign tx_line_oe_out    = q.drv_oe;

endmodule

// file: mdpc_pkg.sv
/*
  Constants, register layout and the decoded selector type for the monitor and line driver
  pin control block. Assumes a single 20 MHz clock and an AXI4-Lite master.
*/
// Contract
// - Four-bit monitor selector picks one transmitter or receiver of channels 1 to 4.
// - Channel 0 is always the observing channel.
// - Selected transmitter tip and ring feed channel 0 receive inputs.
// - Selected receiver tip and ring feed channel 0 receive inputs.
// - Channel 0 recovery presents observed clock and positive/negative data.
// - Remote loopback on channel 0 resends the monitored signal on its transmit pair.
// - Lower three selector bits zero disables monitoring; all channels normal.
// - Driver enable low puts every line driver output in high impedance.
// - Other circuits keep running while the drivers are tri-stated.
// - Clock recovery mode: edge select picks the active clock edge.
// - Data recovery mode: edge select picks the active data level.
package mdpc_pkg;

  // ==========================================================
  // Channels and recovery timing
  // ==========================================================
  localparam int unsigned NUM_CH       = 5;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned BIT_CYCLES   = 8;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_HALF     = 3'h4;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [3:0]  CTRL_OFS     = 4'h0;
  localparam logic [3:0]  STATUS_OFS   = 4'h4;

  // Control fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_ADDR_FOUR_BIT = 4;
  localparam int unsigned CTRL_OE_BIT  = 5;
  localparam int unsigned CTRL_EDGE_BIT = 6;
  localparam int unsigned CTRL_RLB_BIT = 7;
  localparam int unsigned CTRL_CRM_BIT = 8;
  localparam logic [8:0]  CTRL_RESET   = 9'h120;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================
  // Decoded monitor selection
  // ==========================================================
  typedef struct packed {
    logic       active;
    logic       is_tx;
    logic [2:0] chan;
  } mdpc_sel_t;

endpackage

// file: mdpc_recover.sv
/*
  Channel 0 clock and data recovery. Assumes tip and ring inputs are already
  synchronised to ref_clk_in; one bit period is a fixed number of cycles.
*/
`timescale 1ns/10ps
module mdpc_recover
  import mdpc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // Observed line pair
  input  wire logic tip_in,
  input  wire logic ring_in,
  // Presentation controls
  input  wire logic clock_mode_in,
  input  wire logic edge_sel_in,
  // Recovered outputs
  output logic      recovered_clock_out,
  output logic      rx_data_positive_out,
  output logic      rx_data_negative_out
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       acc_p;
    logic       acc_n;
    logic       bit_p;
    logic       bit_n;
    logic       rclk;
    logic       rdp;
    logic       rdn;
  } mdpc_rec_t;

  mdpc_rec_t q;
  mdpc_rec_t d;

  // ==========================================================
  // Next state
  // ==========================================================
  // Marks are OR-ed over a bit period so a short pulse is not missed
  always_comb begin
    d       = q;
    d.cnt   = q.cnt + 3'h1;
    d.acc_p = q.acc_p | tip_in;
    d.acc_n = q.acc_n | ring_in;
    if (q.cnt == BIT_LAST) begin
      d.bit_p = q.acc_p | tip_in;
      d.bit_n = q.acc_n | ring_in;
      d.acc_p = 1'b0;
      d.acc_n = 1'b0;
    end
    if (clock_mode_in) begin
      // High edge select: data valid at rising edge, so clock high late
      d.rclk = (q.cnt >= BIT_HALF) ^ ~edge_sel_in;
      d.rdp  = q.bit_p;
      d.rdn  = q.bit_n;
    end else begin
      // Raw sliced data, no retiming; level polarity follows edge select
      d.rclk = tip_in | ring_in;
      d.rdp  = tip_in ^ ~edge_sel_in;
      d.rdn  = ring_in ^ ~edge_sel_in;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign recovered_clock_out  = q.rclk;
  assign rx_data_positive_out = q.rdp;
  assign rx_data_negative_out = q.rdn;

endmodule

// file: mdpc_top_props.sv
/*
  Checker for mdpc_top: driver enable, line follow and bus handshakes.
  Assumes it sees only the top ports and is bound to every instance.
*/
`timescale 1ns/10ps
module mdpc_top_props
  import mdpc_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk_in,
  input wire logic              arst_n_in,
  // Bus handshakes
  input wire logic              s_axi_awvalid_in,
  input wire logic              s_axi_awready_out,
  input wire logic              s_axi_wvalid_in,
  input wire logic              s_axi_wready_out,
  input wire logic              s_axi_bvalid_out,
  input wire logic [1:0]        s_axi_bresp_out,
  input wire logic              s_axi_bready_in,
  input wire logic              s_axi_arvalid_in,
  input wire logic [3:0]        s_axi_araddr_in,
  input wire logic              s_axi_arready_out,
  input wire logic              s_axi_rvalid_out,
  input wire logic [31:0]       s_axi_rdata_out,
  input wire logic [1:0]        s_axi_rresp_out,
  input wire logic              s_axi_rready_in,
  // Line drivers
  input wire logic [NUM_CH-1:0] tx_data_tip_in,
  input wire logic [NUM_CH-1:0] tx_data_ring_in,
  input wire logic [NUM_CH-1:0] tx_line_tip_out,
  input wire logic [NUM_CH-1:0] tx_line_ring_out,
  input wire logic [NUM_CH-1:0] tx_line_oe_out
);
  // ==========================================
  // One domain, so clock and reset are given once
  // ==========================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_oe_uniform: assert property (tx_line_oe_out == 5'h00 || tx_line_oe_out == 5'h1f)
    else $error("driver enables differ between channels");
  a_off_quiet: assert property (tx_line_oe_out == 5'h00 |-> (tx_line_tip_out | tx_line_ring_out) == 5'h00)
    else $error("line data driven while drivers are off");
  a_tip_follow: assert property (&tx_line_oe_out && $past(&tx_line_oe_out)
    |-> tx_line_tip_out[4:1] == $past(tx_data_tip_in[4:1]))
    else $error("tip output does not follow transmit data");
  a_ring_follow: assert property (&tx_line_oe_out && $past(&tx_line_oe_out)
    |-> tx_line_ring_out[4:1] == $past(tx_data_ring_in[4:1]))
    else $error("ring output does not follow transmit data");
  a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");
  a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read answer changed before taken");
  a_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_r_unmapped: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in >= 4'h8
    |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address accepted while answer pending");
endmodule

bind mdpc_top mdpc_top_props u_props (.ref_clk_in, .arst_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bresp_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_araddr_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_rready_in, .tx_data_tip_in, .tx_data_ring_in, .tx_line_tip_out,
  .tx_line_ring_out, .tx_line_oe_out);

// file: mdpc_line_model.sv
/*
  Line-side board model: static mark levels for receive pins and framer data.
  Assumes the bench pulses load_in one cycle to draw new levels.
*/
`timescale 1ns/10ps
module mdpc_line_model
  import mdpc_pkg::*;
(
  // Clock and request
  input  wire logic         ref_clk_in,
  input  wire logic         load_in,
  // Marks towards the block
  output logic [NUM_CH-1:0] rx_tip_out,
  output logic [NUM_CH-1:0] rx_ring_out,
  output logic [NUM_CH-1:0] tx_tip_out,
  output logic [NUM_CH-1:0] tx_ring_out
);
  logic [NUM_CH-1:0] t_rx;
  logic [NUM_CH-1:0] t_tx;

  // Quiet line until first request
  initial begin
    {rx_tip_out, rx_ring_out, tx_tip_out, tx_ring_out} = '0;
  end

  // Tip and ring never mark at once, as on a real pair
  always @(posedge ref_clk_in) begin
    if (load_in) begin
      t_rx = NUM_CH'($urandom);
      t_tx = NUM_CH'($urandom);
      rx_tip_out  <= t_rx;
      rx_ring_out <= NUM_CH'($urandom) & ~t_rx;
      tx_tip_out  <= t_tx;
      tx_ring_out <= NUM_CH'($urandom) & ~t_tx;
    end
  end
endmodule

// file: test_monitor_and_driver_pin_control.sv
/*
  Self-checking bench for mdpc_top: register port, monitor routing, drivers.
  Assumes mdpc_line_model drives the line side and the checker is bound.
*/
`timescale 1ns/10ps
module test_monitor_and_driver_pin_control
  import mdpc_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, load = 1'b0;
  logic [3:0]        awa = 4'h0, ara = 4'h0, ws = 4'h0;
  logic [31:0]       wd = 32'h0000_0000;
  logic              aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, rclk, rdp, rdn;
  logic [1:0]        b_rsp, r_rsp, r, o;
  logic [31:0]       r_dat, d, msk;
  logic [NUM_CH-1:0] rxt, rxr, txt, txr, lt, lr, loe;
  logic              e;
  int                h;
  int                cyc = 0;
  logic [15:0]       pat = 16'h0000;
  int                fails = 0;
  int                num_checks = 0;

  // 20 MHz reference
  always #25 clk = ~clk;

  // Edge count, used to line up samples with the recovery bit period
  always @(posedge clk) cyc <= cyc + 1;

  mdpc_top uut (.ref_clk_in(clk), .arst_n_in(rst_n), .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa),
    .s_axi_awready_out(aw_rdy), .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_wready_out(w_rdy), .s_axi_bvalid_out(b_vld), .s_axi_bresp_out(b_rsp), .s_axi_bready_in(bre),
    .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara), .s_axi_arready_out(ar_rdy), .s_axi_rvalid_out(r_vld),
    .s_axi_rdata_out(r_dat), .s_axi_rresp_out(r_rsp), .s_axi_rready_in(rre), .rx_line_tip_in(rxt),
    .rx_line_ring_in(rxr), .tx_data_tip_in(txt), .tx_data_ring_in(txr), .tx_line_tip_out(lt),
    .tx_line_ring_out(lr), .tx_line_oe_out(loe), .recovered_clock_out(rclk),
    .rx_data_positive_out(rdp), .rx_data_negative_out(rdn));

  mdpc_line_model u_line (.ref_clk_in(clk), .load_in(load), .rx_tip_out(rxt), .rx_ring_out(rxr),
    .tx_tip_out(txt), .tx_ring_out(txr));

  // ==========================================
  // Reporting
  // ==========================================
  task automatic give_verdict();
    $display("Counts: checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================
  // Bus master; each task starts a fresh cycle so no strobe is set twice
  // ==========================================
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awa <= a; wd <= v; ws <= 4'hf; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    repeat (100) begin
      @(posedge clk);
      if (awv && aw_rdy) awv <= 1'b0;
      if (wv && w_rdy) wv <= 1'b0;
      if (b_vld) begin
        rs = b_rsp;
        bre <= 1'b0;
        return;
      end
    end
    fails++;
    give_verdict();
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    repeat (100) begin
      @(posedge clk);
      if (arv && ar_rdy) arv <= 1'b0;
      if (r_vld) begin
        v = r_dat;
        rs = r_rsp;
        rre <= 1'b0;
        return;
      end
    end
    fails++;
    give_verdict();
  endtask

  // New static line levels, then time to pass the sync flops
  task automatic load_lines(input int settle);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    tick(settle);
  endtask

  // ==========================================
  // Expectations
  // ==========================================
  function automatic logic [31:0] ctrl_word(input logic [3:0] s, input logic oe, ed, rlb, crm);
    return {23'h00_0000, crm, rlb, ed, oe, 1'b0, s};
  endfunction

  function automatic logic act(input logic [3:0] s);
    return s[2:0] >= 3'h1 && s[2:0] <= 3'h4;
  endfunction

  // Pair seen by channel 0: tip in bit 1, ring in bit 0
  function automatic logic [1:0] obs(input logic [3:0] s);
    if (!act(s)) return {rxt[0], rxr[0]};
    if (s[3]) return {txt[s[2:0]], txr[s[2:0]]};
    return {rxt[s[2:0]], rxr[s[2:0]]};
  endfunction

  initial begin
    void'($urandom(91064));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    axi_rd(CTRL_OFS, d, r);
    chk(d, 32'h0000_0120);
    axi_rd(STATUS_OFS, d, r);
    chk(d & 32'h0000_0061, 32'h0000_0020);
    chk(32'(loe), 32'h0000_001f);
    $display("Test reset finished");
    axi_rd(4'h8, d, r);
    chk({d[29:0], r}, {30'h0000_0000, RESP_SLVERR});
    axi_wr(4'hc, 32'h0000_0000, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_wr(STATUS_OFS, 32'hffff_ffff, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_rd(CTRL_OFS, d, r);
    chk(d, 32'h0000_0120);
    $display("Test bus finished");
    // Every selector code, loopback on, random edge select, data mode
    for (int c = 0; c < 16; c++) begin
      e = 1'($urandom);
      axi_wr(CTRL_OFS, ctrl_word(4'(c), 1'b1, e, 1'b1, 1'b0), r);
      load_lines(8);
      axi_rd(STATUS_OFS, d, r);
      msk = act(4'(c)) ? 32'h0000_007f : 32'h0000_0061;
      chk(d & msk, {25'h000_0000, 2'h1, 3'(c), c[3], act(4'(c))} & msk);
      o = obs(4'(c));
      chk(32'({rdp, rdn}), 32'(o ^ {2{~e}}));
      chk(32'(rclk), 32'(o[1] | o[0]));
      chk(32'({lt[0], lr[0]}), 32'(o));
      chk(32'({lt[4:1], lr[4:1]}), 32'({txt[4:1], txr[4:1]}));
    end
    $display("Test monitor finished");
    axi_wr(CTRL_OFS, ctrl_word(4'h2, 1'b0, 1'b1, 1'b0, 1'b0), r);
    load_lines(8);
    chk(32'({loe, lt, lr}), 32'h0000_0000);
    chk(32'({rdp, rdn}), 32'({rxt[2], rxr[2]}));
    axi_wr(CTRL_OFS, ctrl_word(4'h2, 1'b1, 1'b1, 1'b0, 1'b0), r);
    tick(2);
    chk(32'(loe), 32'h0000_001f);
    $display("Test driver enable finished");
    // Clock mode: half-period duty either way, data unaffected by edge select
    for (int k = 0; k < 2; k++) begin
      axi_wr(CTRL_OFS, ctrl_word(4'hb, 1'b1, 1'(k), 1'b0, 1'b1), r);
      load_lines(24);
      // Same period phase in both passes, so the two patterns are comparable
      tick((8 - cyc % 8) % 8);
      h = 0;
      repeat (8) begin
        @(posedge clk);
        h += (rclk === 1'b1);
        pat = {pat[14:0], rclk};
      end
      chk(32'(h), 32'h0000_0004);
      chk(32'(rdp), 32'(txt[3]));
      chk(32'(rdn), 32'(txr[3]));
    end
    chk(32'(pat[15:8] ^ pat[7:0]), 32'h0000_00ff);
    $display("Test clock mode finished");
    give_verdict();
  end
endmodule
